// ### rtl/cpe_pkg.sv
// Package for the clock and power event block: register map, fields, carriers.
// Assumes one system clock; all software access goes over a plain strobe port.
package cpe_pkg;

    // ------------------------------------------------------------
    // Register map (word indices)
    // ------------------------------------------------------------
    localparam int unsigned    ADDR_W          = 3;
    localparam int unsigned    DATA_W          = 16;
    localparam logic [2:0]     ADDR_CTRL       = 3'h0;
    localparam logic [2:0]     ADDR_IRQ_EN     = 3'h1;
    localparam logic [2:0]     ADDR_FLAGS      = 3'h2;
    localparam logic [2:0]     ADDR_TICK_RATE  = 3'h3;
    localparam logic [2:0]     ADDR_AUTO_CTRL  = 3'h4;
    localparam logic [2:0]     ADDR_AUTO_PER   = 3'h5;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned    CTRL_TICK_SRC   = 0;
    localparam int unsigned    CTRL_PSTOP_SEL  = 1;
    localparam int unsigned    CTRL_TICK_PSTOP = 2;
    localparam int unsigned    CTRL_OSC_EN     = 3;
    localparam int unsigned    CTRL_FILT_LO    = 4;
    localparam int unsigned    FILT_W          = 5;
    localparam int unsigned    AUTO_EN         = 0;
    localparam int unsigned    AUTO_SRC        = 1;
    localparam int unsigned    AUTO_PIN        = 2;
    localparam int unsigned    STAT_LO         = 8;

    // Event order shared by flags, enables and request lines
    localparam int unsigned    EV_TICK = 0;
    localparam int unsigned    EV_PLL  = 1;
    localparam int unsigned    EV_OSC  = 2;
    localparam int unsigned    EV_LV   = 3;
    localparam int unsigned    EV_HT   = 4;
    localparam int unsigned    EV_AUTO = 5;
    localparam int unsigned    NUM_EV  = 6;

    // Synchronised pin order
    localparam int unsigned    PIN_IRC    = 0;
    localparam int unsigned    PIN_OSC    = 1;
    localparam int unsigned    PIN_ACLK   = 2;
    localparam int unsigned    PIN_LOCK   = 3;
    localparam int unsigned    PIN_LV     = 4;
    localparam int unsigned    PIN_HT     = 5;
    localparam int unsigned    NUM_PIN    = 6;

    localparam logic [15:0]    RST_WORD   = 16'h0000;
    localparam logic [15:0]    RST_RATE   = 16'h00ff;
    localparam logic [15:0]    RST_PERIOD = 16'h00ff;
    localparam int unsigned    QUAL_EDGES = 64;

    typedef struct packed {
        logic [2:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

endpackage

// ### rtl/clock_power_events.sv
// Event logic of a clock and power unit: tick timer, lock and oscillator
// status flags, voltage and temperature change flags, autonomous timer.
// Assumes external clocks and status levels arrive asynchronous to clk_sys.
`timescale 1ns/1ps

// Function
// - Tick counts internal or oscillator clock
// - Tick halts in stop unless pseudo-stop oscillator
// - Period end sets flag, restarts immediately
// - Tick request only while enable set
// - Rate register write restarts tick period
// - Lock change either way sets flag
// - Writing one clears lock flag
// - Lock request suppressed when enable zero
// - Oscillator disabled keeps qualified status zero
// - Zero filter: qualify right after lock
// - Any qualified toggle sets oscillator flag
// - Losing lock clears qualified status
// - Oscillator request only while enabled
// - Low-voltage change sets flag, enable gates
// - Temperature change sets flag, enable gates
// - Auto source select writable only while disabled
// - Auto period writable only while disabled
// - Auto timer periodic, flags, restarts itself
// - Auto request when flag and enable
// - Stopped bus clock freezes auto count when bus clock is the source
// - Enable and pin enable drive waveform out
module clock_power_events #(
    parameter int unsigned  CNT_W = 16
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire cpe_pkg::reg_req_t    reg_req,
    output logic [15:0]               reg_rdata,
    input  wire logic                 internal_ref_clk,
    input  wire logic                 osc_clk_a,
    input  wire logic                 auto_rc_clk,
    input  wire logic                 pll_locked,
    input  wire logic                 low_voltage_status,
    input  wire logic                 high_temp_status,
    input  wire logic                 stop_mode,
    input  wire logic                 bus_clk_stopped,
    output logic                      tick_irq,
    output logic                      pll_sync_irq,
    output logic                      osc_status_irq,
    output logic                      low_voltage_irq,
    output logic                      high_temp_irq,
    output logic                      auto_timer_irq,
    output logic                      osc_qualified,
    output logic                      auto_timer_wave_out
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic rising(input logic now_v, input logic old_v);
        rising = now_v & ~old_v;
    endfunction

    function automatic logic wr_hit(input cpe_pkg::reg_req_t r, input logic [2:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [cpe_pkg::NUM_PIN-1:0] pin_meta_reg;
    logic [cpe_pkg::NUM_PIN-1:0] pin_sync_reg;
    logic [cpe_pkg::NUM_PIN-1:0] pin_old_reg;
    logic [cpe_pkg::NUM_PIN-1:0] pin_raw;

    assign pin_raw = {high_temp_status, low_voltage_status, pll_locked,
                      auto_rc_clk, osc_clk_a, internal_ref_clk};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
            pin_old_reg  <= '0;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
            pin_old_reg  <= pin_sync_reg;
        end
    end

    logic irc_edge;
    logic osc_edge;
    logic aclk_edge;
    logic locked;
    assign irc_edge  = rising(pin_sync_reg[cpe_pkg::PIN_IRC], pin_old_reg[cpe_pkg::PIN_IRC]);
    assign osc_edge  = rising(pin_sync_reg[cpe_pkg::PIN_OSC], pin_old_reg[cpe_pkg::PIN_OSC]);
    assign aclk_edge = rising(pin_sync_reg[cpe_pkg::PIN_ACLK], pin_old_reg[cpe_pkg::PIN_ACLK]);
    assign locked    = pin_sync_reg[cpe_pkg::PIN_LOCK];

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [15:0]               ctrl_reg;
    logic [cpe_pkg::NUM_EV-1:0] irq_en_reg;
    logic [CNT_W-1:0]          tick_rate_reg;
    logic                      auto_en_reg;
    logic                      auto_src_reg;
    logic                      auto_pin_reg;
    logic [CNT_W-1:0]          auto_period_reg;

    logic tick_src_select;
    logic pseudo_stop_select;
    logic tick_pstop_enable;
    logic ext_osc_enable;
    logic [cpe_pkg::FILT_W-1:0] spike_filter_setting;
    assign tick_src_select      = ctrl_reg[cpe_pkg::CTRL_TICK_SRC];
    assign pseudo_stop_select   = ctrl_reg[cpe_pkg::CTRL_PSTOP_SEL];
    assign tick_pstop_enable    = ctrl_reg[cpe_pkg::CTRL_TICK_PSTOP];
    assign ext_osc_enable       = ctrl_reg[cpe_pkg::CTRL_OSC_EN];
    assign spike_filter_setting = ctrl_reg[cpe_pkg::CTRL_FILT_LO +: cpe_pkg::FILT_W];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_reg      <= cpe_pkg::RST_WORD;
            irq_en_reg    <= '0;
            tick_rate_reg <= CNT_W'(cpe_pkg::RST_RATE);
        end else begin
            if (wr_hit(reg_req, cpe_pkg::ADDR_CTRL)) begin
                ctrl_reg <= reg_req.wdata;
            end
            if (wr_hit(reg_req, cpe_pkg::ADDR_IRQ_EN)) begin
                irq_en_reg <= reg_req.wdata[cpe_pkg::NUM_EV-1:0];
            end
            if (wr_hit(reg_req, cpe_pkg::ADDR_TICK_RATE)) begin
                tick_rate_reg <= reg_req.wdata[CNT_W-1:0];
            end
        end
    end

    // Source and period only move while the timer is off, so a running
    // period never sees a half-changed configuration
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            auto_en_reg     <= 1'b0;
            auto_src_reg    <= 1'b0;
            auto_pin_reg    <= 1'b0;
            auto_period_reg <= CNT_W'(cpe_pkg::RST_PERIOD);
        end else begin
            if (wr_hit(reg_req, cpe_pkg::ADDR_AUTO_CTRL)) begin
                auto_en_reg  <= reg_req.wdata[cpe_pkg::AUTO_EN];
                auto_pin_reg <= reg_req.wdata[cpe_pkg::AUTO_PIN];
                if (!auto_en_reg) begin
                    auto_src_reg <= reg_req.wdata[cpe_pkg::AUTO_SRC];
                end
            end
            if (wr_hit(reg_req, cpe_pkg::ADDR_AUTO_PER) && !auto_en_reg) begin
                auto_period_reg <= reg_req.wdata[CNT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Tick timer
    // ------------------------------------------------------------
    logic [CNT_W-1:0] tick_cnt_reg;
    logic             tick_step;
    logic             tick_run;
    logic             tick_done;

    assign tick_step = tick_src_select ? osc_edge : irc_edge;
    assign tick_run  = !stop_mode ||
                       (pseudo_stop_select && tick_src_select && tick_pstop_enable);
    assign tick_done = tick_step && tick_run && (tick_cnt_reg == tick_rate_reg);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= '0;
        end else if (wr_hit(reg_req, cpe_pkg::ADDR_TICK_RATE)) begin
            tick_cnt_reg <= '0;
        end else if (tick_done) begin
            tick_cnt_reg <= '0;
        end else if (tick_step && tick_run) begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Oscillator qualification
    // ------------------------------------------------------------
    // Nonzero filter settings wait a fixed number of oscillator edges;
    // the adaptive bandwidth itself is not modelled here.
    logic [7:0] qual_cnt_reg;
    logic       osc_qual_reg;
    logic       qual_ok;
    logic       full_stop;

    assign full_stop = stop_mode && !pseudo_stop_select;
    assign qual_ok   = (spike_filter_setting == '0) ||
                       (qual_cnt_reg == 8'(cpe_pkg::QUAL_EDGES));

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            qual_cnt_reg <= '0;
            osc_qual_reg <= 1'b0;
        end else if (!ext_osc_enable || !locked || full_stop) begin
            qual_cnt_reg <= '0;
            osc_qual_reg <= 1'b0;
        end else begin
            if (osc_edge && !qual_ok) begin
                qual_cnt_reg <= qual_cnt_reg + 1'b1;
            end
            osc_qual_reg <= qual_ok;
        end
    end
    assign osc_qualified = osc_qual_reg;

    // ------------------------------------------------------------
    // Autonomous timer
    // ------------------------------------------------------------
    logic [CNT_W-1:0] auto_cnt_reg;
    logic             auto_step;
    logic             auto_done;
    logic             wave_reg;

    assign auto_step = auto_src_reg ? !bus_clk_stopped : aclk_edge;
    assign auto_done = auto_en_reg && auto_step && (auto_cnt_reg == auto_period_reg);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            auto_cnt_reg <= '0;
            wave_reg     <= 1'b0;
        end else if (!auto_en_reg) begin
            auto_cnt_reg <= '0;
            wave_reg     <= 1'b0;
        end else if (auto_done) begin
            auto_cnt_reg <= '0;
            wave_reg     <= ~wave_reg;
        end else if (auto_step) begin
            auto_cnt_reg <= auto_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            auto_timer_wave_out <= 1'b0;
        end else begin
            auto_timer_wave_out <= auto_en_reg && auto_pin_reg && wave_reg;
        end
    end

    // ------------------------------------------------------------
    // Flags: a set in the clearing cycle wins
    // ------------------------------------------------------------
    logic [cpe_pkg::NUM_EV-1:0] flags_reg;
    logic [cpe_pkg::NUM_EV-1:0] flag_set;
    logic [cpe_pkg::NUM_EV-1:0] flag_clr;
    logic                       osc_qual_old_reg;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            osc_qual_old_reg <= 1'b0;
        end else begin
            osc_qual_old_reg <= osc_qual_reg;
        end
    end

    always_comb begin
        flag_set                   = '0;
        flag_set[cpe_pkg::EV_TICK] = tick_done;
        flag_set[cpe_pkg::EV_PLL]  = pin_sync_reg[cpe_pkg::PIN_LOCK] ^
                                     pin_old_reg[cpe_pkg::PIN_LOCK];
        flag_set[cpe_pkg::EV_OSC]  = osc_qual_reg ^ osc_qual_old_reg;
        flag_set[cpe_pkg::EV_LV]   = pin_sync_reg[cpe_pkg::PIN_LV] ^
                                     pin_old_reg[cpe_pkg::PIN_LV];
        flag_set[cpe_pkg::EV_HT]   = pin_sync_reg[cpe_pkg::PIN_HT] ^
                                     pin_old_reg[cpe_pkg::PIN_HT];
        flag_set[cpe_pkg::EV_AUTO] = auto_done;
    end

    assign flag_clr = wr_hit(reg_req, cpe_pkg::ADDR_FLAGS) ?
                      reg_req.wdata[cpe_pkg::NUM_EV-1:0] : '0;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
        end
    end

    // Request lines stay up until software clears the flag or its enable
    assign tick_irq        = flags_reg[cpe_pkg::EV_TICK] & irq_en_reg[cpe_pkg::EV_TICK];
    assign pll_sync_irq    = flags_reg[cpe_pkg::EV_PLL]  & irq_en_reg[cpe_pkg::EV_PLL];
    assign osc_status_irq  = flags_reg[cpe_pkg::EV_OSC]  & irq_en_reg[cpe_pkg::EV_OSC];
    assign low_voltage_irq = flags_reg[cpe_pkg::EV_LV]   & irq_en_reg[cpe_pkg::EV_LV];
    assign high_temp_irq   = flags_reg[cpe_pkg::EV_HT]   & irq_en_reg[cpe_pkg::EV_HT];
    assign auto_timer_irq  = flags_reg[cpe_pkg::EV_AUTO] & irq_en_reg[cpe_pkg::EV_AUTO];

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                cpe_pkg::ADDR_CTRL:      reg_rdata <= ctrl_reg;
                cpe_pkg::ADDR_IRQ_EN:    reg_rdata <= 16'(irq_en_reg);
                cpe_pkg::ADDR_FLAGS:     reg_rdata <= 16'({pin_sync_reg[cpe_pkg::PIN_HT],
                                             pin_sync_reg[cpe_pkg::PIN_LV], osc_qual_reg,
                                             locked, 2'h0, flags_reg});
                cpe_pkg::ADDR_TICK_RATE: reg_rdata <= 16'(tick_rate_reg);
                cpe_pkg::ADDR_AUTO_CTRL: reg_rdata <= 16'({auto_pin_reg, auto_src_reg,
                                                           auto_en_reg});
                cpe_pkg::ADDR_AUTO_PER:  reg_rdata <= 16'(auto_period_reg);
                default:                 reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_tick_end;
        tick_done && !wr_hit(reg_req, cpe_pkg::ADDR_TICK_RATE);
    endsequence

    a_tick_period_end: assert property (s_tick_end |=> flags_reg[cpe_pkg::EV_TICK]
        && tick_cnt_reg == '0) else $error("tick end missed");
    a_tick_rate_restart: assert property (wr_hit(reg_req, cpe_pkg::ADDR_TICK_RATE)
        |=> tick_cnt_reg == '0) else $error("rate write no restart");
    a_tick_stop_halt: assert property ((stop_mode && !pseudo_stop_select)
        |=> $stable(tick_cnt_reg) || $past(wr_hit(reg_req, cpe_pkg::ADDR_TICK_RATE)))
        else $error("tick ran in stop");
    a_lock_change_flag: assert property ($changed(locked)
        |-> ##1 flags_reg[cpe_pkg::EV_PLL]) else $error("lock flag missed");
    a_osc_off_zero: assert property (!ext_osc_enable |=> !osc_qualified)
        else $error("qualified while off");
    a_lock_loss_qual: assert property ($fell(locked) |=> !osc_qualified)
        else $error("qualified after lock loss");
    a_osc_toggle_flag: assert property ($changed(osc_qualified)
        |=> flags_reg[cpe_pkg::EV_OSC]) else $error("osc flag missed");
    a_auto_period_hold: assert property (auto_en_reg
        |=> $stable(auto_period_reg) && $stable(auto_src_reg))
        else $error("auto config moved");
    a_auto_bus_freeze: assert property (auto_en_reg && auto_src_reg
        && bus_clk_stopped |=> $stable(auto_cnt_reg))
        else $error("auto count moved");
    a_irq_gate_and: assert property (pll_sync_irq == (flags_reg[cpe_pkg::EV_PLL]
        && irq_en_reg[cpe_pkg::EV_PLL])) else $error("lock irq gate");
    a_irq_held_clear: assert property (tick_irq && !flag_clr[cpe_pkg::EV_TICK]
        && !wr_hit(reg_req, cpe_pkg::ADDR_IRQ_EN) |=> tick_irq) else $error("tick irq dropped");
    a_wave_pin_off: assert property (!auto_pin_reg |=> !auto_timer_wave_out)
        else $error("wave without pin enable");

endmodule

// ### dv/clock_power_events_test.sv
// Self-checking bench for the clock and power event block.
// Assumes the block's own assertions are active; drives every port directly.
`timescale 1ns/1ps

module clock_power_events_test;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic               clk_sys;
    logic               rst;
    cpe_pkg::reg_req_t  reg_req;
    logic [15:0]        reg_rdata;
    logic               internal_ref_clk, osc_clk_a, auto_rc_clk;
    logic               pll_locked, low_voltage_status, high_temp_status;
    logic               stop_mode, bus_clk_stopped;
    logic               tick_irq, pll_sync_irq, osc_status_irq;
    logic               low_voltage_irq, high_temp_irq, auto_timer_irq;
    logic               osc_qualified, auto_timer_wave_out;
    int                 num_errors;
    int                 checks;

    clock_power_events dut (
        .clk_sys(clk_sys), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .internal_ref_clk(internal_ref_clk), .osc_clk_a(osc_clk_a),
        .auto_rc_clk(auto_rc_clk), .pll_locked(pll_locked),
        .low_voltage_status(low_voltage_status), .high_temp_status(high_temp_status),
        .stop_mode(stop_mode), .bus_clk_stopped(bus_clk_stopped),
        .tick_irq(tick_irq), .pll_sync_irq(pll_sync_irq), .osc_status_irq(osc_status_irq),
        .low_voltage_irq(low_voltage_irq), .high_temp_irq(high_temp_irq),
        .auto_timer_irq(auto_timer_irq), .osc_qualified(osc_qualified),
        .auto_timer_wave_out(auto_timer_wave_out)
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        if (num_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", name, e, g);
            num_errors++;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_req.addr  <= a;
        reg_req.wdata <= d;
        reg_req.wr    <= 1'b1;
        @(posedge clk_sys);
        reg_req.wr    <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_req.addr <= a;
        reg_req.rd   <= 1'b1;
        @(posedge clk_sys);
        reg_req.rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Slow clocks are sampled as data, so each edge is held 4 cycles per level
    task automatic edges(input int which, input int n);
        repeat (n) begin
            for (int lvl = 1; lvl >= 0; lvl--) begin
                @(posedge clk_sys);
                case (which)
                    0: internal_ref_clk <= lvl[0];
                    1: osc_clk_a <= lvl[0];
                    default: auto_rc_clk <= lvl[0];
                endcase
                repeat (3) @(posedge clk_sys);
            end
        end
        idle(4);
    endtask

    // Cycles between two wave toggles; a missing toggle ends the run
    task automatic wave_gap(output int n);
        logic w;
        #1;
        w = auto_timer_wave_out;
        for (n = 0; n < 50 && auto_timer_wave_out === w; n++) idle(1);
        w = auto_timer_wave_out;
        for (n = 0; n < 50 && auto_timer_wave_out === w; n++) idle(1);
        if (n >= 50) begin
            num_errors++;
            wrap_up();
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        logic [15:0] d;
        rd(3'h6, d);
        chk("unmapped read", 16'h0000, d);
        wr(3'h7, 16'hffff);
        rd(3'h7, d);
        chk("unmapped write", 16'h0000, d);
        rd(cpe_pkg::ADDR_TICK_RATE, d);
        chk("rate reset", 16'h00ff, d);
    endtask

    task automatic t_tick();
        logic [15:0] d;
        wr(cpe_pkg::ADDR_IRQ_EN, 16'h0001);
        wr(cpe_pkg::ADDR_TICK_RATE, 16'h0003);
        edges(0, 3);
        chk("tick early", 16'h0000, tick_irq);
        edges(0, 1);
        chk("tick end", 16'h0001, tick_irq);
        idle(20);
        chk("tick held", 16'h0001, tick_irq);
        wr(cpe_pkg::ADDR_FLAGS, 16'h0001);
        idle(2);
        chk("tick cleared", 16'h0000, tick_irq);
        edges(1, 4);
        chk("tick other src", 16'h0000, tick_irq);
        edges(0, 3);
        wr(cpe_pkg::ADDR_TICK_RATE, 16'h0003);
        edges(0, 3);
        chk("tick restart", 16'h0000, tick_irq);
        edges(0, 1);
        chk("tick after restart", 16'h0001, tick_irq);
        wr(cpe_pkg::ADDR_FLAGS, 16'h0001);
        stop_mode <= 1'b1;
        edges(0, 4);
        chk("tick halted in stop", 16'h0000, tick_irq);
        wr(cpe_pkg::ADDR_CTRL, 16'h0007);
        wr(cpe_pkg::ADDR_TICK_RATE, 16'h0003);
        edges(1, 4);
        chk("tick pseudo stop", 16'h0001, tick_irq);
        @(posedge clk_sys);
        stop_mode <= 1'b0;
        wr(cpe_pkg::ADDR_IRQ_EN, 16'h0000);
        idle(2);
        chk("tick masked", 16'h0000, tick_irq);
        rd(cpe_pkg::ADDR_FLAGS, d);
        chk("tick flag kept", 16'h0001, d[0]);
        wr(cpe_pkg::ADDR_FLAGS, 16'h0001);
        wr(cpe_pkg::ADDR_CTRL, 16'h0000);
    endtask

    task automatic t_pll_osc();
        wr(cpe_pkg::ADDR_IRQ_EN, 16'h0006);
        pll_locked <= 1'b1;
        idle(6);
        chk("lock rise", 16'h0001, pll_sync_irq);
        chk("qual osc off", 16'h0000, osc_qualified);
        wr(cpe_pkg::ADDR_FLAGS, 16'h0000);
        idle(2);
        chk("lock write zero", 16'h0001, pll_sync_irq);
        wr(cpe_pkg::ADDR_FLAGS, 16'h0002);
        idle(2);
        chk("lock write one", 16'h0000, pll_sync_irq);
        wr(cpe_pkg::ADDR_CTRL, 16'h0008);
        idle(4);
        chk("qual after lock", 16'h0001, osc_qualified);
        chk("osc rise flag", 16'h0001, osc_status_irq);
        wr(cpe_pkg::ADDR_CTRL, 16'h0018);
        edges(1, cpe_pkg::QUAL_EDGES - 1);
        chk("qual filter early", 16'h0000, osc_qualified);
        edges(1, 1);
        chk("qual filter done", 16'h0001, osc_qualified);
        wr(cpe_pkg::ADDR_FLAGS, 16'h0004);
        pll_locked <= 1'b0;
        idle(6);
        chk("qual lost", 16'h0000, osc_qualified);
        chk("osc fall flag", 16'h0001, osc_status_irq);
        chk("lock fall", 16'h0001, pll_sync_irq);
        wr(cpe_pkg::ADDR_IRQ_EN, 16'h0000);
        idle(2);
        chk("lock masked", 16'h0000, pll_sync_irq);
        chk("osc masked", 16'h0000, osc_status_irq);
        wr(cpe_pkg::ADDR_FLAGS, 16'h0006);
        wr(cpe_pkg::ADDR_CTRL, 16'h0000);
    endtask

    task automatic t_status();
        wr(cpe_pkg::ADDR_IRQ_EN, 16'h0018);
        low_voltage_status <= 1'b1;
        high_temp_status   <= 1'b1;
        idle(6);
        chk("lv rise", 16'h0001, low_voltage_irq);
        chk("ht rise", 16'h0001, high_temp_irq);
        wr(cpe_pkg::ADDR_FLAGS, 16'h0008);
        idle(2);
        chk("lv cleared", 16'h0000, low_voltage_irq);
        chk("ht kept", 16'h0001, high_temp_irq);
        wr(cpe_pkg::ADDR_FLAGS, 16'h0010);
        low_voltage_status <= 1'b0;
        high_temp_status   <= 1'b0;
        idle(6);
        wr(cpe_pkg::ADDR_IRQ_EN, 16'h0010);
        idle(2);
        chk("lv masked", 16'h0000, low_voltage_irq);
        chk("ht fall", 16'h0001, high_temp_irq);
        wr(cpe_pkg::ADDR_FLAGS, 16'h0018);
    endtask

    task automatic t_auto();
        logic [15:0] d;
        logic        w;
        int          n;
        wr(cpe_pkg::ADDR_AUTO_PER, 16'h0003);
        wr(cpe_pkg::ADDR_AUTO_CTRL, 16'h0007);
        wave_gap(n);
        chk("auto period", 16'h0004, n[15:0]);
        wr(cpe_pkg::ADDR_IRQ_EN, 16'h0020);
        idle(10);
        chk("auto irq", 16'h0001, auto_timer_irq);
        wr(cpe_pkg::ADDR_AUTO_PER, 16'h0007);
        rd(cpe_pkg::ADDR_AUTO_PER, d);
        chk("auto period locked", 16'h0003, d);
        wr(cpe_pkg::ADDR_AUTO_CTRL, 16'h0005);
        rd(cpe_pkg::ADDR_AUTO_CTRL, d);
        chk("auto src locked", 16'h0007, d);
        @(posedge clk_sys);
        bus_clk_stopped <= 1'b1;
        idle(2);
        w = auto_timer_wave_out;
        idle(12);
        chk("auto frozen", {15'h0000, w}, auto_timer_wave_out);
        @(posedge clk_sys);
        bus_clk_stopped <= 1'b0;
        wr(cpe_pkg::ADDR_AUTO_CTRL, 16'h0000);
        idle(2);
        chk("wave off", 16'h0000, auto_timer_wave_out);
        wr(cpe_pkg::ADDR_AUTO_PER, 16'h0001);
        wr(cpe_pkg::ADDR_AUTO_CTRL, 16'h0005);
        edges(2, 1);
        chk("rc early", 16'h0000, auto_timer_wave_out);
        edges(2, 1);
        chk("rc period", 16'h0001, auto_timer_wave_out);
        wr(cpe_pkg::ADDR_AUTO_CTRL, 16'h0000);
        wr(cpe_pkg::ADDR_FLAGS, 16'h003f);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        num_errors = 0;
        checks     = 0;
        rst        = 1'b1;
        reg_req    = '0;
        {internal_ref_clk, osc_clk_a, auto_rc_clk} = 3'h0;
        {pll_locked, low_voltage_status, high_temp_status} = 3'h0;
        {stop_mode, bus_clk_stopped} = 2'h0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_tick();
        t_pll_osc();
        t_status();
        t_auto();
        wrap_up();
    end

endmodule
